// ### hdl/fsr_recorder.sv
// Overview of operation
// - On the selected trigger, capture the chosen magnitudes into a new record.
// - Trigger is a breaker trip or a user-chosen signal, each enabled separately.
// - Control bit chooses per-unit or primary values for storage.
// - Control bit chooses overcurrent or voltage fault type as the recorded kind.
// - Sampling happens in the trigger cycle itself, no added delay.
// - Any listed stage trip shows fault type on display, and captured values when a capture falls in the same cycle.
// - Display only comes up while the view enable setting is active.
// - The user-selected reset input clears the displayed fault values.
// - Twelve latest records are kept and readable.
// - Up to eight magnitude slots, each with its own selection.
// - Records keep both fault types and tripped stage for supervisory readout.
// - Magnitudes come from current, voltage, power and impedance measurements.
`timescale 1ns/10ps
`default_nettype none
module fsr_recorder
	import fsr_pkg::*;
#(
	parameter int NUM_SLOTS = FSR_NUM_SLOTS,
	parameter int DEPTH = FSR_DEPTH,
	parameter int NUM_MEAS = FSR_NUM_MEAS
) (
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	input wire logic [FSR_ADDR_W-1:0] addr_i,
	input wire logic [FSR_DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [FSR_DATA_W-1:0] rdata_o,
	input wire logic [NUM_MEAS*FSR_MEAS_W-1:0] pu_meas_i,
	input wire logic [NUM_MEAS*FSR_MEAS_W-1:0] prim_meas_i,
	input wire logic breaker_trip_i,
	input wire logic user_trig_i,
	input wire logic [FSR_STAGES-1:0] stage_trip_i,
	input wire logic [FSR_FTYPE_W-1:0] oc_type_i,
	input wire logic [FSR_FTYPE_W-1:0] volt_type_i,
	input wire logic fault_reset_i,
	output logic view_active_o,
	output logic [NUM_SLOTS*FSR_MEAS_W-1:0] view_vals_o,
	output logic [FSR_FTYPE_W-1:0] view_type_o,
	output logic [FSR_STAGE_W-1:0] view_stage_o,
	output logic [FSR_CNT_W-1:0] rec_count_o,
	output logic irq_o
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [FSR_CTRL_W-1:0] ctrl;
		logic [NUM_SLOTS*FSR_SEL_W-1:0] sel;
		fsr_record_t [DEPTH-1:0] mem;
		logic [FSR_IDX_W-1:0] wptr;
		logic [FSR_CNT_W-1:0] count;
		logic [FSR_IDX_W-1:0] rd_idx;
		logic [FSR_EV_W-1:0] irq_stat;
		logic [FSR_EV_W-1:0] irq_en;
		logic trig_d;
		logic view_active;
		fsr_record_t view;
		logic [FSR_FTYPE_W-1:0] view_type;
		logic [FSR_DATA_W-1:0] rdata;
		logic irq;
	} fsr_state_t;

	fsr_state_t st_r;
	fsr_state_t st_nxt;

	logic [NUM_SLOTS*FSR_MEAS_W-1:0] snap_vals;
	logic trig_lvl;
	logic trig_rise;
	logic [FSR_STAGE_W-1:0] stage_id;
	logic any_stage;

	fsr_snap #(
		.NUM_SLOTS(NUM_SLOTS),
		.NUM_MEAS(NUM_MEAS)
	) u_snap (
		.pu_meas_i(pu_meas_i),
		.prim_meas_i(prim_meas_i),
		.sel_i(st_r.sel),
		.primary_i(st_r.ctrl[FSR_CTRL_PRIMARY]),
		.vals_o(snap_vals)
	);

	// ------------------------------------------------------------
	// Trigger and stage decode
	// ------------------------------------------------------------
	assign trig_lvl = (st_r.ctrl[FSR_CTRL_BRK_TRIG] & breaker_trip_i) |
		(st_r.ctrl[FSR_CTRL_USER_TRIG] & user_trig_i);
	assign trig_rise = trig_lvl & ~st_r.trig_d;
	assign any_stage = |stage_trip_i;

	// Lowest tripped stage wins; stage ids are 1-based, zero means none
	always_comb begin
		stage_id = '0;
		for (int i = FSR_STAGES - 1; i >= 0; i--) begin
			if (stage_trip_i[i]) begin
				stage_id = FSR_STAGE_W'(i + 1);
			end
		end
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		fsr_record_t rec;
		logic [FSR_EV_W-1:0] ev;
		logic [FSR_ADDR_W-1:0] a;
		int k;
		rec = '0;
		ev = '0;
		a = addr_i;
		k = 0;
		st_nxt = st_r;
		st_nxt.trig_d = trig_lvl;

		rec.vals = snap_vals;
		rec.oc_type = oc_type_i;
		rec.volt_type = volt_type_i;
		rec.stage = stage_id;
		rec.fault_kind = st_r.ctrl[FSR_CTRL_VTYPE];

		if (trig_rise) begin
			st_nxt.mem[st_r.wptr] = rec;
			// Ring pointer: oldest slot is reused once full
			if (st_r.wptr == FSR_IDX_W'(DEPTH - 1)) begin
				st_nxt.wptr = '0;
			end else begin
				st_nxt.wptr = st_r.wptr + FSR_IDX_W'(1);
			end
			if (st_r.count != FSR_CNT_W'(DEPTH)) begin
				st_nxt.count = st_r.count + FSR_CNT_W'(1);
			end else begin
				ev[FSR_EV_WRAP] = 1'b1;
			end
			ev[FSR_EV_CAPTURE] = 1'b1;
		end

		// Fault view: reset input has priority over a fresh trip
		if (fault_reset_i) begin
			st_nxt.view_active = 1'b0;
			st_nxt.view = '0;
		end else if (any_stage && st_r.ctrl[FSR_CTRL_VIEW_EN]) begin
			st_nxt.view_active = 1'b1;
			st_nxt.view = trig_rise ? rec : st_r.view;
			if (!trig_rise) begin
				st_nxt.view.stage = stage_id;
				st_nxt.view.oc_type = oc_type_i;
				st_nxt.view.volt_type = volt_type_i;
				st_nxt.view.fault_kind = st_r.ctrl[FSR_CTRL_VTYPE];
			end
			ev[FSR_EV_VIEW] = ~st_r.view_active;
		end else if (!st_r.ctrl[FSR_CTRL_VIEW_EN]) begin
			st_nxt.view_active = 1'b0;
		end
		// Shown type resolved here so the output leaves a flip-flop directly
		st_nxt.view_type = st_nxt.view.fault_kind ? st_nxt.view.volt_type : st_nxt.view.oc_type;

		// Register writes
		if (wr_i) begin
			if (a == FSR_REG_CTRL) begin
				st_nxt.ctrl = wdata_i[FSR_CTRL_W-1:0];
			end else if (a == FSR_REG_IRQ_EN) begin
				st_nxt.irq_en = wdata_i[FSR_EV_W-1:0];
			end else if (a == FSR_REG_IRQ_CLR) begin
				st_nxt.irq_stat = st_r.irq_stat & ~wdata_i[FSR_EV_W-1:0];
			end else if (a == FSR_REG_RD_IDX) begin
				st_nxt.rd_idx = wdata_i[FSR_IDX_W-1:0];
			end
			for (int s = 0; s < NUM_SLOTS; s++) begin
				if (a == FSR_ADDR_W'(FSR_REG_SEL_BASE + s * FSR_REG_STRIDE)) begin
					st_nxt.sel[s*FSR_SEL_W +: FSR_SEL_W] = wdata_i[FSR_SEL_W-1:0];
				end
			end
		end
		// Set wins over a clear in the same cycle
		st_nxt.irq_stat = st_nxt.irq_stat | ev;
		st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_en);

		// Register reads, data valid in the following cycle only
		st_nxt.rdata = '0;
		if (rd_i) begin
			if (a == FSR_REG_CTRL) begin
				st_nxt.rdata = FSR_DATA_W'(st_r.ctrl);
			end else if (a == FSR_REG_STATUS) begin
				st_nxt.rdata = FSR_DATA_W'({st_r.view_active, st_r.wptr, st_r.count});
			end else if (a == FSR_REG_IRQ_STAT) begin
				st_nxt.rdata = FSR_DATA_W'(st_r.irq_stat);
			end else if (a == FSR_REG_IRQ_EN) begin
				st_nxt.rdata = FSR_DATA_W'(st_r.irq_en);
			end else if (a == FSR_REG_RD_IDX) begin
				st_nxt.rdata = FSR_DATA_W'(st_r.rd_idx);
			end else if (a == FSR_REG_RD_META && st_r.rd_idx < FSR_IDX_W'(DEPTH)) begin
				st_nxt.rdata = FSR_DATA_W'({st_r.mem[st_r.rd_idx].stage,
					st_r.mem[st_r.rd_idx].fault_kind,
					st_r.mem[st_r.rd_idx].oc_type,
					st_r.mem[st_r.rd_idx].volt_type});
			end
			for (k = 0; k < NUM_SLOTS; k++) begin
				if (a == FSR_ADDR_W'(FSR_REG_SEL_BASE + k * FSR_REG_STRIDE)) begin
					st_nxt.rdata = FSR_DATA_W'(st_r.sel[k*FSR_SEL_W +: FSR_SEL_W]);
				end
				if (a == FSR_ADDR_W'(FSR_REG_RD_VAL_BASE + k * FSR_REG_STRIDE) &&
					st_r.rd_idx < FSR_IDX_W'(DEPTH)) begin
					st_nxt.rdata = FSR_DATA_W'(st_r.mem[st_r.rd_idx].vals[k*FSR_MEAS_W +: FSR_MEAS_W]);
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_r <= '0;
			st_r.ctrl <= FSR_CTRL_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rdata_o = st_r.rdata;
	assign view_active_o = st_r.view_active;
	assign view_vals_o = st_r.view.vals;
	assign view_type_o = st_r.view_type;
	assign view_stage_o = st_r.view.stage;
	assign rec_count_o = st_r.count;
	assign irq_o = st_r.irq;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	capture_count_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		trig_rise && st_r.count < FSR_CNT_W'(DEPTH) |=> st_r.count == $past(st_r.count) + FSR_CNT_W'(1))
		else $error("capture did not add a record");
	capture_now_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		trig_rise |=> st_r.mem[$past(st_r.wptr)].vals == $past(snap_vals))
		else $error("captured values not sampled at trigger");
	trig_select_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		!st_r.ctrl[FSR_CTRL_BRK_TRIG] && !st_r.ctrl[FSR_CTRL_USER_TRIG] |=> $stable(st_r.count))
		else $error("capture with no trigger source enabled");
	kind_store_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		trig_rise |=> st_r.mem[$past(st_r.wptr)].fault_kind == $past(st_r.ctrl[FSR_CTRL_VTYPE]))
		else $error("fault kind not stored");
	view_show_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		any_stage && st_r.ctrl[FSR_CTRL_VIEW_EN] && !fault_reset_i |=> view_active_o)
		else $error("trip did not raise fault view");
	view_gate_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		!st_r.ctrl[FSR_CTRL_VIEW_EN] |=> !view_active_o)
		else $error("fault view shown while disabled");
	view_clear_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		fault_reset_i |=> !view_active_o && view_vals_o == '0)
		else $error("fault reset did not clear view");
	depth_cap_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		st_r.count <= FSR_CNT_W'(DEPTH) && st_r.wptr < FSR_IDX_W'(DEPTH))
		else $error("record store exceeded depth");
	ring_wrap_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		trig_rise && st_r.wptr == FSR_IDX_W'(DEPTH - 1) |=> st_r.wptr == '0)
		else $error("ring pointer did not wrap");

	// ------------------------------------------------------------
	// Checks: record contents
	// ------------------------------------------------------------
	type_store_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		trig_rise |=> st_r.mem[$past(st_r.wptr)].oc_type == $past(oc_type_i) &&
			st_r.mem[$past(st_r.wptr)].volt_type == $past(volt_type_i))
		else $error("fault types not stored");
	stage_store_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		trig_rise |=> st_r.mem[$past(st_r.wptr)].stage == $past(stage_id))
		else $error("tripped stage not stored");
	stage_none_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		(stage_id == '0) == !any_stage)
		else $error("stage id disagrees with trip inputs");
	// Slot 0 and the last slot bound the selection mux; the middle slots share its code
	primary_pick_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		st_r.ctrl[FSR_CTRL_PRIMARY] |->
			snap_vals[FSR_MEAS_W-1:0] == prim_meas_i[st_r.sel[FSR_SEL_W-1:0]*FSR_MEAS_W +: FSR_MEAS_W])
		else $error("primary value not selected");
	unit_pick_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		!st_r.ctrl[FSR_CTRL_PRIMARY] |->
			snap_vals[FSR_MEAS_W-1:0] == pu_meas_i[st_r.sel[FSR_SEL_W-1:0]*FSR_MEAS_W +: FSR_MEAS_W])
		else $error("per-unit value not selected");
	slot_last_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		snap_vals[(NUM_SLOTS-1)*FSR_MEAS_W +: FSR_MEAS_W] == (st_r.ctrl[FSR_CTRL_PRIMARY] ?
			prim_meas_i[st_r.sel[(NUM_SLOTS-1)*FSR_SEL_W +: FSR_SEL_W]*FSR_MEAS_W +: FSR_MEAS_W] :
			pu_meas_i[st_r.sel[(NUM_SLOTS-1)*FSR_SEL_W +: FSR_SEL_W]*FSR_MEAS_W +: FSR_MEAS_W]))
		else $error("last slot picks wrong magnitude");

	// ------------------------------------------------------------
	// Checks: trigger and ring
	// ------------------------------------------------------------
	held_once_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		trig_rise |=> !trig_rise)
		else $error("held trigger captured twice");
	count_hold_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		!trig_rise |=> $stable(st_r.count) && $stable(st_r.wptr))
		else $error("record count moved without a capture");
	full_keep_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		trig_rise && st_r.count == FSR_CNT_W'(DEPTH) |=> st_r.count == FSR_CNT_W'(DEPTH) &&
			st_r.irq_stat[FSR_EV_WRAP])
		else $error("full store did not overwrite oldest");
	capture_flag_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		trig_rise |=> st_r.irq_stat[FSR_EV_CAPTURE])
		else $error("capture event lost");

	// ------------------------------------------------------------
	// Checks: fault view
	// ------------------------------------------------------------
	view_vals_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		trig_rise && any_stage && st_r.ctrl[FSR_CTRL_VIEW_EN] && !fault_reset_i |=>
			view_vals_o == $past(snap_vals))
		else $error("fault view lacks captured values");
	view_stage_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		any_stage && st_r.ctrl[FSR_CTRL_VIEW_EN] && !fault_reset_i |=> view_stage_o == $past(stage_id))
		else $error("fault view shows wrong stage");
	view_type_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		any_stage && st_r.ctrl[FSR_CTRL_VIEW_EN] && !fault_reset_i |=>
			view_type_o == ($past(st_r.ctrl[FSR_CTRL_VTYPE]) ? $past(volt_type_i) : $past(oc_type_i)))
		else $error("fault view shows wrong type");
	view_quiet_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		!any_stage && !view_active_o |=> !view_active_o)
		else $error("fault view raised without a trip");

	// ------------------------------------------------------------
	// Checks: register bus
	// ------------------------------------------------------------
	read_idle_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		!rd_i |=> rdata_o == '0)
		else $error("read data stood past its cycle");
	meta_read_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		rd_i && addr_i == FSR_REG_RD_META && st_r.rd_idx < FSR_IDX_W'(DEPTH) |=>
			rdata_o[FSR_FTYPE_W-1:0] == $past(st_r.mem[st_r.rd_idx].volt_type))
		else $error("record meta read wrong");
	far_index_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		rd_i && addr_i == FSR_REG_RD_META && st_r.rd_idx >= FSR_IDX_W'(DEPTH) |=> rdata_o == '0)
		else $error("read beyond store returned data");
	irq_level_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		irq_o == |(st_r.irq_stat & st_r.irq_en))
		else $error("interrupt disagrees with enabled status");
endmodule
`default_nettype wire

// ### hdl/fsr_pkg.sv
`default_nettype none
package fsr_pkg;
	// ------------------------------------------------------------
	// Sizes
	// ------------------------------------------------------------
	localparam int FSR_NUM_SLOTS = 8;
	localparam int FSR_DEPTH = 12;
	localparam int FSR_MEAS_W = 16;
	localparam int FSR_NUM_MEAS = 64;
	localparam int FSR_SEL_W = 6;
	localparam int FSR_STAGES = 15;
	localparam int FSR_STAGE_W = 4;
	localparam int FSR_FTYPE_W = 4;
	localparam int FSR_IDX_W = 4;
	localparam int FSR_CNT_W = 4;
	localparam int FSR_ADDR_W = 8;
	localparam int FSR_DATA_W = 32;

	// ------------------------------------------------------------
	// Register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] FSR_REG_CTRL = 8'h00;
	localparam logic [7:0] FSR_REG_STATUS = 8'h04;
	localparam logic [7:0] FSR_REG_IRQ_STAT = 8'h08;
	localparam logic [7:0] FSR_REG_IRQ_EN = 8'h0c;
	localparam logic [7:0] FSR_REG_IRQ_CLR = 8'h10;
	localparam logic [7:0] FSR_REG_SEL_BASE = 8'h20;
	localparam logic [7:0] FSR_REG_RD_IDX = 8'h40;
	localparam logic [7:0] FSR_REG_RD_META = 8'h44;
	localparam logic [7:0] FSR_REG_RD_VAL_BASE = 8'h60;
	localparam logic [7:0] FSR_REG_STRIDE = 8'h04;

	// CTRL fields
	localparam int FSR_CTRL_PRIMARY = 0;
	localparam int FSR_CTRL_VTYPE = 1;
	localparam int FSR_CTRL_VIEW_EN = 2;
	localparam int FSR_CTRL_USER_TRIG = 3;
	localparam int FSR_CTRL_BRK_TRIG = 4;
	localparam int FSR_CTRL_W = 5;
	localparam logic [4:0] FSR_CTRL_RST = 5'h10;

	// Interrupt events
	localparam int FSR_EV_CAPTURE = 0;
	localparam int FSR_EV_VIEW = 1;
	localparam int FSR_EV_WRAP = 2;
	localparam int FSR_EV_W = 3;

	typedef struct packed {
		logic [FSR_ADDR_W-1:0] addr;
		logic [FSR_DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} fsr_bus_req_t;

	typedef struct packed {
		logic [FSR_STAGE_W-1:0] stage;
		logic fault_kind;
		logic [FSR_FTYPE_W-1:0] oc_type;
		logic [FSR_FTYPE_W-1:0] volt_type;
		logic [FSR_NUM_SLOTS*FSR_MEAS_W-1:0] vals;
	} fsr_record_t;
endpackage
`default_nettype wire

// ### hdl/fsr_snap.sv
`timescale 1ns/10ps
`default_nettype none
module fsr_snap
	import fsr_pkg::*;
#(
	parameter int NUM_SLOTS = FSR_NUM_SLOTS,
	parameter int NUM_MEAS = FSR_NUM_MEAS
) (
	input wire logic [NUM_MEAS*FSR_MEAS_W-1:0] pu_meas_i,
	input wire logic [NUM_MEAS*FSR_MEAS_W-1:0] prim_meas_i,
	input wire logic [NUM_SLOTS*FSR_SEL_W-1:0] sel_i,
	input wire logic primary_i,
	output logic [NUM_SLOTS*FSR_MEAS_W-1:0] vals_o
);
	// Purely combinational mux so the trigger cycle samples without delay
	for (genvar s = 0; s < NUM_SLOTS; s++) begin : g_slot
		logic [FSR_SEL_W-1:0] sel;
		assign sel = sel_i[s*FSR_SEL_W +: FSR_SEL_W];
		assign vals_o[s*FSR_MEAS_W +: FSR_MEAS_W] = primary_i ?
			prim_meas_i[sel*FSR_MEAS_W +: FSR_MEAS_W] :
			pu_meas_i[sel*FSR_MEAS_W +: FSR_MEAS_W];
	end
endmodule
`default_nettype wire

// ### tb/fsr_meas_model.sv
`timescale 1ns/10ps
`default_nettype none
// -------------------------------------------------
// Measurement subsystem stand-in
// -------------------------------------------------
// Each entry carries its own index and a shared epoch, so a wrong slot or a late sample shows
module fsr_meas_model
	import fsr_pkg::*;
(
	input wire logic [7:0] epoch_i,
	output logic [FSR_NUM_MEAS*FSR_MEAS_W-1:0] pu_o,
	output logic [FSR_NUM_MEAS*FSR_MEAS_W-1:0] prim_o
);
	always_comb begin
		for (int n = 0; n < FSR_NUM_MEAS; n++) begin
			pu_o[n*16+:16] = {epoch_i, 2'b00, 6'(n)};
			prim_o[n*16+:16] = {~epoch_i, 2'b01, 6'(n)};
		end
	end
endmodule
`default_nettype wire

// ### tb/fsr_recorder_test.sv
`timescale 1ns/10ps
`default_nettype none
module fsr_recorder_test
	import fsr_pkg::*;
;
	typedef struct packed {
		logic [4:0] ctrl;
		logic src;
		logic hit;
	} fsr_row_t;
	fsr_row_t rows [6] = '{'{5'h10, 1'b0, 1'b1}, '{5'h11, 1'b0, 1'b1}, '{5'h12, 1'b0, 1'b1},
		'{5'h0b, 1'b1, 1'b1}, '{5'h08, 1'b0, 1'b0}, '{5'h10, 1'b1, 1'b0}};
	logic clk_sys_i = '0, resetn_i = '0, wr_i = '0, rd_i = '0, brk = '0, usr = '0, frst = '0;
	logic [7:0] addr_i = '0, ep = '0;
	logic [31:0] wdata_i = '0, rdata_o, rv;
	logic [14:0] stg = 15'h0004;
	logic [3:0] oc = 4'h9, vt = 4'h6, vtype, vstage, cnt_o;
	logic [FSR_NUM_MEAS*FSR_MEAS_W-1:0] pu, prim;
	logic [FSR_NUM_SLOTS*FSR_MEAS_W-1:0] vv;
	logic vact, irq;
	int bad_count = 0, checked = 0, ncap = 0;

	fsr_meas_model meas (.epoch_i(ep), .pu_o(pu), .prim_o(prim));
	fsr_recorder dut (.clk_sys_i, .resetn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
		.pu_meas_i(pu), .prim_meas_i(prim), .breaker_trip_i(brk), .user_trig_i(usr),
		.stage_trip_i(stg), .oc_type_i(oc), .volt_type_i(vt), .fault_reset_i(frst),
		.view_active_o(vact), .view_vals_o(vv), .view_type_o(vtype), .view_stage_o(vstage),
		.rec_count_o(cnt_o), .irq_o(irq));

	// -------------------------------------------------
	// Helpers
	// -------------------------------------------------
	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic close_out;
		if (bad_count == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge clk_sys_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_sys_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(logic [7:0] a);
		@(posedge clk_sys_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_sys_i);
		rd_i <= 1'b0;
		#1 rv = rdata_o;
	endtask
	// Inputs move away right after the trigger cycle, so only a same-cycle sample matches
	task automatic cap(bit src, logic [7:0] e);
		@(posedge clk_sys_i);
		ep <= e;
		brk <= !src;
		usr <= src;
		@(posedge clk_sys_i);
		brk <= 1'b0;
		usr <= 1'b0;
		ep <= ~e;
		@(posedge clk_sys_i);
		#1;
	endtask
	function automatic logic [15:0] mv(int s, logic [7:0] e, bit p);
		logic [5:0] n;
		n = 6'(s * 7 + 2);
		return p ? {~e, 2'b01, n} : {e, 2'b00, n};
	endfunction
	task automatic chkrec(int i, logic [7:0] e, logic [4:0] c);
		wr(FSR_REG_RD_IDX, 32'(i));
		for (int s = 0; s < 8; s++) begin
			rd(FSR_REG_RD_VAL_BASE + 8'(4 * s));
			chk("rec val", rv, {16'h0000, mv(s, e, c[0])});
		end
		rd(FSR_REG_RD_META);
		chk("rec meta", rv, {19'h0, 4'h3, c[1], oc, vt});
	endtask

	initial begin
		forever #5 clk_sys_i = ~clk_sys_i;
	end
	initial begin
		repeat (50000) @(posedge clk_sys_i);
		bad_count++;
		close_out();
	end

	// -------------------------------------------------
	// Stimulus
	// -------------------------------------------------
	initial begin
		repeat (20) @(posedge clk_sys_i);
		resetn_i <= 1'b1;
		rd(FSR_REG_CTRL);
		chk("ctrl rst", rv, 32'h10);
		rd(8'hfc);
		chk("unmapped", rv, 32'h0);
		for (int s = 0; s < 8; s++) begin
			wr(FSR_REG_SEL_BASE + 8'(4 * s), 32'(s * 7 + 2));
		end
		foreach (rows[i]) begin
			wr(FSR_REG_CTRL, 32'(rows[i].ctrl));
			cap(rows[i].src, 8'h20 + 8'(i));
			ncap += int'(rows[i].hit);
			chk("count", 32'(cnt_o), 32'(ncap));
			if (rows[i].hit) begin
				chkrec(ncap - 1, 8'h20 + 8'(i), rows[i].ctrl);
			end
		end
		@(posedge clk_sys_i);
		brk <= 1'b1;
		repeat (5) @(posedge clk_sys_i);
		brk <= 1'b0;
		@(posedge clk_sys_i);
		#1;
		ncap++;
		chk("held trig", 32'(cnt_o), 32'(ncap));
		rd(FSR_REG_IRQ_STAT);
		chk("irq stat", rv, 32'h1);
		chk("irq masked", 32'(irq), 32'h0);
		wr(FSR_REG_IRQ_EN, 32'h1);
		@(posedge clk_sys_i);
		#1;
		chk("irq on", 32'(irq), 32'h1);
		wr(FSR_REG_IRQ_CLR, 32'h7);
		@(posedge clk_sys_i);
		#1;
		chk("irq off", 32'(irq), 32'h0);
		wr(FSR_REG_IRQ_EN, 32'h4);
		while (ncap < 14) begin
			cap(1'b0, 8'(ncap));
			ncap++;
			chk("full count", 32'(cnt_o), 32'(ncap > FSR_DEPTH ? FSR_DEPTH : ncap));
		end
		chk("irq wrap", 32'(irq), 32'h1);
		chkrec(1, 8'h0d, 5'h10);
		chkrec(0, 8'h0c, 5'h10);
		chkrec(2, 8'h22, 5'h12);
		chk("view off", 32'(vact), 32'h0);
		wr(FSR_REG_CTRL, 32'h14);
		cap(1'b0, 8'h77);
		chk("view on", 32'(vact), 32'h1);
		chk("view stage", 32'(vstage), 32'h3);
		chk("view type", 32'(vtype), 32'(oc));
		chk("view val", 32'(vv[15:0]), 32'(mv(0, 8'h77, 1'b0)));
		rd(FSR_REG_IRQ_STAT);
		chk("irq all", rv, 32'h7);
		@(posedge clk_sys_i);
		frst <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		#1;
		chk("view clr", 32'(vact), 32'h0);
		chk("view vals clr", 32'(vv[15:0]), 32'h0);
		@(posedge clk_sys_i);
		frst <= 1'b0;
		stg <= 15'h0100;
		wr(FSR_REG_CTRL, 32'h16);
		cap(1'b0, 8'h55);
		chk("volt type", 32'(vtype), 32'(vt));
		chk("new stage", 32'(vstage), 32'h9);
		chk("new val", 32'(vv[127:112]), 32'(mv(7, 8'h55, 1'b0)));
		wr(FSR_REG_CTRL, 32'h10);
		@(posedge clk_sys_i);
		#1;
		chk("view hidden", 32'(vact), 32'h0);
		chk("view kept", 32'(vv[127:112]), 32'(mv(7, 8'h55, 1'b0)));
		rd(FSR_REG_STATUS);
		chk("status", rv, 32'h04c);
		@(posedge clk_sys_i);
		#1;
		chk("read gone", rdata_o, 32'h0);
		wr(FSR_REG_RD_IDX, 32'hd);
		rd(FSR_REG_RD_META);
		chk("far index", rv, 32'h0);
		// Reset in mid-run must empty the store and restore the trigger setting
		@(posedge clk_sys_i);
		resetn_i <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
		resetn_i <= 1'b1;
		#1;
		chk("rst count", 32'(cnt_o), 32'h0);
		chk("rst view", 32'(vact), 32'h0);
		chk("rst irq", 32'(irq), 32'h0);
		rd(FSR_REG_CTRL);
		chk("rst ctrl", rv, 32'(FSR_CTRL_RST));
		cap(1'b0, 8'h66);
		chk("rst capture", 32'(cnt_o), 32'h1);
		close_out();
	end
endmodule
`default_nettype wire
